/* design/slave_xfer_defines.svh */
// Timing counts and field widths of the slave port sequencer
`ifndef SLAVE_XFER_DEFINES_SVH
`define SLAVE_XFER_DEFINES_SVH
`define ADDR_W 32
`define DATA_W 32
`define LANES 4
`define CNT_W 8
`define LANES_ALL_OFF 4'hF
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`endif

/* design/slave_xfer_pkg.sv */
// Types of the slave port sequencer
`include "slave_xfer_defines.svh"
package slave_xfer_pkg;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_setup = 2'b01,
		st_wait = 2'b11,
		st_final = 2'b10
	} phase_t;

	// Transfer request from the master side
	typedef struct packed {
		logic rd;
		logic wr;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
		logic [`LANES-1:0] lanes_n;
	} req_t;

	// Slave-facing outputs
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
		logic [`LANES-1:0] lanes_n;
		logic rd_n;
		logic wr_n;
		logic sel;
	} port_t;

	typedef struct packed {
		phase_t ph;
		logic is_rd;
		logic [`CNT_W-1:0] cnt;
		port_t port;
		logic [`DATA_W-1:0] rdata;
		logic done;
		logic busy;
	} state_t;
endpackage

/* design/slave_xfer.sv */
// Bus-side sequencer for single read and write transfers to one slave port
//
// Summary of operation
// [R1] Stall high at read end: do not capture
// [R2] Slave raises stall within first cycle
// [R3] Capture on first edge without stall
// [R4] Wait unbounded while stall held
// [R5] Stall mode forces setup count to zero
// [R6] Read strobe after N setup cycles
// [R7] Select asserted from first cycle
// [R8] Read lasts setup plus waits plus one
// [R9] Strobe off in setup, on in waits
// [R10] Same setup count for writes
// [R11] Select may stay for back-to-back transfer; the code drops it for one idle cycle between transfers
// [R12] Zero-wait write completes in one cycle
// [R13] Slow slave must request wait states
// [R14] Write end drops all strobes together
// [R15] Lane enables active low, one per byte
// [R16] Address word-aligned, lanes pick bytes
// [R17] Slave ignores inputs when unselected
// [R18] Slave samples on clock, not edges
// [R19] Slave must eventually release stall
// [R20] Fixed read waits same every read
// [R21] Zero setup: strobe in first cycle
`include "slave_xfer_defines.svh"
module slave_xfer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Configuration
	input wire logic stall_mode,
	input wire logic [`CNT_W-1:0] setup_cycles,
	input wire logic [`CNT_W-1:0] read_waits,
	// Master request and answer
	input wire slave_xfer_pkg::req_t req,
	output logic busy,
	output logic done,
	output logic [`DATA_W-1:0] rdata,
	// Slave port
	output slave_xfer_pkg::port_t port,
	input wire logic [`DATA_W-1:0] slave_rdata,
	input wire logic slave_stall
);
	// Same-clock slave outputs need no synchroniser
	slave_xfer_pkg::state_t s_q, s_d;
	logic [`CNT_W-1:0] eff_setup;

	// One-step count down; the zero test stays with the caller
	function automatic logic [`CNT_W-1:0] cnt_dec(input logic [`CNT_W-1:0] c);
		return c - `CNT_ONE;
	endfunction

	// Read word taken and the port released on the same edge
	function automatic slave_xfer_pkg::state_t finish_read(input slave_xfer_pkg::state_t s,
		input logic [`DATA_W-1:0] word);
		slave_xfer_pkg::state_t r;
		r = s;
		r.rdata = word;
		r.done = 1'b1;
		r.ph = slave_xfer_pkg::st_idle;
		r.port.sel = 1'b0;
		r.port.rd_n = 1'b1;
		r.busy = 1'b0;
		return r;
	endfunction

	assign busy = s_q.busy;
	assign done = s_q.done;
	assign rdata = s_q.rdata;
	assign port = s_q.port;

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		eff_setup = stall_mode ? `CNT_ZERO : setup_cycles; // R5
		s_d = s_q;
		s_d.done = 1'b0;
		unique case (s_q.ph)
			slave_xfer_pkg::st_idle: begin
				// Port released for one idle cycle between transfers, never held over
				// Costs a cycle per back-to-back access, but every transfer stays framed
				s_d.port.sel = 1'b0; // R11 R14
				s_d.port.wr_n = 1'b1; // R14
				s_d.port.rd_n = 1'b1;
				s_d.port.lanes_n = `LANES_ALL_OFF;
				s_d.busy = 1'b0;
				if (req.rd || req.wr) begin
					s_d.busy = 1'b1;
					s_d.is_rd = req.rd;
					s_d.port.addr = req.addr; // R16
					s_d.port.wdata = req.wdata;
					s_d.port.lanes_n = req.lanes_n; // R15
					s_d.port.sel = 1'b1; // R7
					s_d.cnt = eff_setup; // R10
					if (eff_setup != `CNT_ZERO) begin
						s_d.ph = slave_xfer_pkg::st_setup; // R6
					end else if (req.rd) begin
						s_d.port.rd_n = 1'b0; // R21
						s_d.cnt = read_waits; // R20
						s_d.ph = slave_xfer_pkg::st_wait;
					end else begin
						s_d.port.wr_n = 1'b0; // R12
						s_d.ph = slave_xfer_pkg::st_final;
					end
				end
			end
			slave_xfer_pkg::st_setup: begin
				// Strobe stays off until the last setup cycle ends
				if (s_q.cnt == `CNT_ONE) begin
					s_d.cnt = read_waits; // R8
					s_d.ph = s_q.is_rd ? slave_xfer_pkg::st_wait : slave_xfer_pkg::st_final;
					if (s_q.is_rd) begin
						s_d.port.rd_n = 1'b0; // R9
					end else begin
						s_d.port.wr_n = 1'b0;
					end
				end else begin
					s_d.cnt = cnt_dec(s_q.cnt);
				end
			end
			slave_xfer_pkg::st_wait: begin
				if (stall_mode) begin
					// No time-out: a stuck stall hangs here
					if (!slave_stall) begin // R1 R4
						s_d = finish_read(s_d, slave_rdata); // R3
					end
				end else if (s_q.cnt == `CNT_ZERO) begin
					s_d = finish_read(s_d, slave_rdata); // R8
				end else begin
					s_d.cnt = cnt_dec(s_q.cnt); // R20
				end
			end
			slave_xfer_pkg::st_final: begin
				// Slave took the write at this edge; all strobes fall together
				s_d.done = 1'b1; // R12
				s_d.ph = slave_xfer_pkg::st_idle;
				s_d.port.sel = 1'b0; // R14
				s_d.port.wr_n = 1'b1; // R14
				s_d.port.lanes_n = `LANES_ALL_OFF;
				s_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.ph <= slave_xfer_pkg::st_idle;
			s_q.port.rd_n <= 1'b1;
			s_q.port.wr_n <= 1'b1;
			s_q.port.lanes_n <= `LANES_ALL_OFF;
		end else begin
			s_q <= s_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	a_stall_blocks: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		(s_q.ph == slave_xfer_pkg::st_wait && stall_mode && slave_stall) |=> !s_q.done)
		else $error("read captured while stall held");
	a_capture_after: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		(s_q.ph == slave_xfer_pkg::st_wait && stall_mode && !slave_stall) |=> (s_q.done && rdata == $past(slave_rdata)))
		else $error("read not captured after stall released");
	a_stall_holds: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
		(s_q.ph == slave_xfer_pkg::st_wait && stall_mode && slave_stall) |=> (s_q.ph == slave_xfer_pkg::st_wait && !port.rd_n))
		else $error("left wait under stall");
	a_no_setup_stall: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
		stall_mode |-> (s_q.ph != slave_xfer_pkg::st_setup || !$past(stall_mode)))
		else $error("setup used in stall mode");
	a_setup_strobe: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
		(s_q.ph == slave_xfer_pkg::st_setup) |-> (port.rd_n && port.wr_n && port.sel))
		else $error("strobe during setup");
	a_sel_first: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
		(s_q.ph == slave_xfer_pkg::st_idle && (req.rd || req.wr)) |=> port.sel)
		else $error("select late");
	a_zero_setup_rd: assert property (@(posedge sys_clk) disable iff (!nrst) // R21
		(s_q.ph == slave_xfer_pkg::st_idle && req.rd && !stall_mode && setup_cycles == `CNT_ZERO) |=> !port.rd_n)
		else $error("read strobe late");
	a_fixed_read: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
		(s_q.ph == slave_xfer_pkg::st_idle && req.rd && !stall_mode && setup_cycles == `CNT_ZERO
		&& read_waits == `CNT_ONE) |=> !done [*2] ##1 done)
		else $error("fixed read length wrong");
	a_write_one: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		(s_q.ph == slave_xfer_pkg::st_idle && req.wr && !req.rd && (stall_mode || setup_cycles == `CNT_ZERO))
		|=> (!port.wr_n && port.sel) ##1 (done && port.wr_n && !port.sel))
		else $error("zero-wait write wrong");
	a_write_end: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
		$rose(port.wr_n) |-> $fell(port.sel))
		else $error("write strobes not dropped together");
	c_stall_read: cover property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.ph == slave_xfer_pkg::st_wait && slave_stall && stall_mode) ##1 !slave_stall ##1 done);
	c_setup_read: cover property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.ph == slave_xfer_pkg::st_setup) ##1 (s_q.ph == slave_xfer_pkg::st_wait));
	c_write: cover property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.ph == slave_xfer_pkg::st_final) ##1 done);
	c_fixed_read: cover property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.ph == slave_xfer_pkg::st_wait && !stall_mode && s_q.cnt != `CNT_ZERO)
		##1 (s_q.ph == slave_xfer_pkg::st_wait && s_q.cnt == `CNT_ZERO) ##1 done);
	c_byte_write: cover property (@(posedge sys_clk) disable iff (!nrst)
		(s_q.ph == slave_xfer_pkg::st_final && port.lanes_n == 4'hE) ##1 done);
	a_setup_delay: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
		(s_q.ph == slave_xfer_pkg::st_idle && req.rd && !stall_mode && setup_cycles == `CNT_ONE)
		|=> (port.sel && port.rd_n) ##1 (port.sel && !port.rd_n))
		else $error("read strobe not delayed by setup");
	a_fixed_waits: assert property (@(posedge sys_clk) disable iff (!nrst) // R20
		(s_q.ph == slave_xfer_pkg::st_wait && !stall_mode && s_q.cnt != `CNT_ZERO)
		|=> (s_q.ph == slave_xfer_pkg::st_wait && !done && !port.rd_n))
		else $error("fixed read ended early");
	a_lanes_pass: assert property (@(posedge sys_clk) disable iff (!nrst) // R15 R16
		(s_q.ph == slave_xfer_pkg::st_idle && (req.rd || req.wr))
		|=> (port.lanes_n == $past(req.lanes_n) && port.addr == $past(req.addr)))
		else $error("address or lanes not passed as given");
	a_end_lanes: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
		$rose(port.wr_n) |-> (port.lanes_n == `LANES_ALL_OFF && !busy))
		else $error("lanes still enabled after write");
	a_write_setup: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		(s_q.ph == slave_xfer_pkg::st_idle && req.wr && !req.rd && !stall_mode && setup_cycles != `CNT_ZERO)
		|=> (port.sel && port.wr_n && s_q.ph == slave_xfer_pkg::st_setup))
		else $error("write setup not applied");
	a_write_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		(s_q.ph == slave_xfer_pkg::st_final) |-> (port.sel && !port.wr_n && port.rd_n))
		else $error("write strobe missing in strobe cycle");
endmodule

/* tb/slave_model.sv */
// Behavioural slave peripheral with stall and lane-masked write store
module slave_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Bus side
	input wire slave_xfer_pkg::port_t port,
	input wire logic [7:0] stall_len,
	output logic [31:0] slave_rdata,
	output logic slave_stall,
	output logic [31:0] word_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic rd_on;
	assign rd_on = port.sel && !port.rd_n;
	assign slave_stall = rd_on && (cnt_q < stall_len);
	// Inverted while stalled or unselected, so an early capture shows
	assign slave_rdata = (port.addr ^ 32'hA5A5_5A5A) ^ {32{!(rd_on && !slave_stall)}};
	////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00;
			word_q <= 32'h0000_0000;
		end else begin
			cnt_q <= rd_on ? cnt_q + 8'h01 : 8'h00;
			// Clocked capture only, strobe edges may glitch
			for (int i = 0; i < 4; i++) begin
				if (port.sel && !port.wr_n && !port.lanes_n[i]) begin
					word_q[i*8 +: 8] <= port.wdata[i*8 +: 8];
				end
			end
		end
	end
endmodule

/* tb/slave_xfer_tb.sv */
// Self-checking bench for the slave port sequencer
module slave_xfer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, nrst, stall_mode, busy, done, slave_stall, first_sel, first_rdn;
	logic [7:0] setup_cycles, read_waits, stall_len;
	logic [31:0] rdata, slave_rdata, word_q;
	logic [31:0] exp_w = 32'h0000_0000;
	slave_xfer_pkg::req_t req;
	slave_xfer_pkg::port_t port;
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;
	int lat;
	logic [3:0] lane_tab [5] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hB};
	slave_xfer slave_xfer_i (.sys_clk(sys_clk), .nrst(nrst), .stall_mode(stall_mode), .setup_cycles(setup_cycles),
		.read_waits(read_waits), .req(req), .busy(busy), .done(done), .rdata(rdata), .port(port),
		.slave_rdata(slave_rdata), .slave_stall(slave_stall));
	slave_model slave_model_i (.sys_clk(sys_clk), .nrst(nrst), .port(port), .stall_len(stall_len),
		.slave_rdata(slave_rdata), .slave_stall(slave_stall), .word_q(word_q));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One transfer; waits are bounded so a stuck port cannot hang
	task automatic run(input logic rd, sm, input logic [7:0] n, w, k, input logic [31:0] a, d,
		input logic [3:0] ln, input int exp_lat);
		@(posedge sys_clk);
		stall_mode <= sm;
		setup_cycles <= n;
		read_waits <= w;
		stall_len <= k;
		req <= '{rd, !rd, a, d, ln};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		req.wr <= 1'b0;
		#1;
		first_sel = port.sel;
		first_rdn = port.rd_n;
		lat = 0;
		do begin
			@(posedge sys_clk);
			#1;
			lat++;
		end while (done !== 1'b1 && lat < 100);
		for (int i = 0; i < 4; i++) begin
			if (!rd && !ln[i])
				exp_w[i*8 +: 8] = d[i*8 +: 8];
		end
		check(32'(lat), 32'(exp_lat));
		check(32'({first_sel, first_rdn}), 32'({1'b1, rd ? (!sm && n != 8'h00) : 1'b1}));
		check(32'({port.sel, port.rd_n, port.wr_n}), 32'h0000_0003);
		check(rd ? rdata : word_q, rd ? a ^ 32'hA5A5_5A5A : exp_w);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		nrst = 1'b0;
		{stall_mode, setup_cycles, read_waits, stall_len} = '0;
		req = '0;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 5; i++)
			run(0, 0, 0, 0, 0, 32'h0000_0010, 32'h1111_1111 * (i + 1), lane_tab[i], 1);
		run(0, 0, 2, 0, 0, 32'h0000_0014, 32'hDEAD_BEEF, 4'h0, 3);
		run(1, 0, 1, 1, 0, 32'h0000_0100, 32'h0000_0000, 4'h0, 3);
		run(1, 0, 2, 3, 0, 32'h0000_0104, 32'h0000_0000, 4'h0, 6);
		run(1, 0, 0, 2, 0, 32'h0000_0108, 32'h0000_0000, 4'h0, 3);
		run(1, 0, 0, 1, 0, 32'h0000_010C, 32'h0000_0000, 4'h0, 2);
		// Setup count must be ignored with stall control
		for (int k = 0; k < 41; k += 20)
			run(1, 1, 3, 2, 8'(k), 32'h0000_0200 + k, 32'h0000_0000, 4'h0, k + 1);
		print_verdict();
	end
endmodule
